// ---- hpi_device.sv ----
`timescale 1ns/1ps
module hpi_device
   import hpi_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   hpi_if.device port,
   output logic auxReq,
   output logic auxWrite,
   output logic [31:0] auxAddr,
   output logic [31:0] auxWData,
   output logic [3:0] auxByteEn,
   input wire logic auxDone,
   input wire logic [31:0] auxRData,
   input wire logic cpuCtlWrite,
   input wire logic [15:0] cpuCtlWData,
   output logic [15:0] cpuCtlRData,
   output logic cpuInterrupt
);
   typedef enum logic [3:0] {
      HD_IDLE = 4'b0001,
      HD_FETCH = 4'b0010,
      HD_ACT = 4'b0100,
      HD_HOLD = 4'b1000
   } hd_state_t;
   typedef struct packed {
      logic [1:0] s1; // strobe sync stage one
      logic [1:0] s2;
      logic [15:0] d1;
      logic [15:0] d2;
      logic [4:0] c1; // sel, order, rw, cs
      logic [4:0] c2;
      logic [1:0] b1;
      logic [1:0] b2;
      hd_state_t st;
      logic [1:0] sel;
      logic order;
      logic rw;
      logic [15:0] ctl;
      logic [31:0] ptr;
      logic [31:0] wbuf;
      logic [3:0] wbe;
      logic [31:0] rbuf;
      logic busy;
      logic opWrite;
      logic [31:0] opAddr;
      logic [15:0] rdOut;
      logic oeN;
      logic irq;
   } hd_reg_t;
   hd_reg_t r_ff, nxt_r;
   logic strobeOn;
   logic [15:0] half;
   logic blocked;

   function automatic logic isBlocked(input logic [31:0] a);
      return (a >= SKIP_BASE) && (a <= SKIP_LAST);
   endfunction

   // either data strobe low while selected starts an access
   assign strobeOn = r_ff.c2[0] && !(r_ff.s2[0] && r_ff.s2[1]);
   assign blocked = isBlocked(r_ff.ptr);

   always_comb begin
      nxt_r = r_ff;
      nxt_r.s1 = {port.dataStrobeTwoN, port.dataStrobeOneN};
      nxt_r.s2 = r_ff.s1;
      nxt_r.d1 = port.hostDataIn;
      nxt_r.d2 = r_ff.d1;
      nxt_r.c1 = {port.registerSelectLines, port.halfwordOrderInput, port.readWriteSelect,
                  !port.chipSelectN};
      nxt_r.c2 = r_ff.c1;
      nxt_r.b1 = port.writeByteLanesN;
      nxt_r.b2 = r_ff.b1;
      nxt_r.irq = 1'b0;
      half = r_ff.d2;
      if (r_ff.busy && auxDone) begin
         nxt_r.busy = 1'b0;
         if (!r_ff.opWrite) begin
            nxt_r.rbuf = auxRData;
         end
      end
      if (cpuCtlWrite) begin
         nxt_r.ctl[CTL_ORDER_BIT] = cpuCtlWData[CTL_ORDER_BIT];
         nxt_r.ctl[CTL_HOSTINT_BIT] = cpuCtlWData[CTL_HOSTINT_BIT];
         if (cpuCtlWData[CTL_DEVINT_BIT]) begin
            nxt_r.ctl[CTL_DEVINT_BIT] = 1'b0;
         end
      end
      nxt_r.ctl[CTL_READY_BIT] = !nxt_r.busy;
      unique case (r_ff.st)
         HD_IDLE: begin
            if (strobeOn && !r_ff.busy) begin
               nxt_r.sel = r_ff.c2[4:3];
               nxt_r.order = r_ff.c2[2];
               nxt_r.rw = r_ff.c2[1];
               nxt_r.st = HD_ACT;
               // fixed reads fetch fresh data before the first halfword is driven
               if (r_ff.c2[4:3] == SEL_DATA_FIX && r_ff.c2[1] && !r_ff.c2[2] && !blocked) begin
                  nxt_r.busy = 1'b1;
                  nxt_r.opWrite = 1'b0;
                  nxt_r.opAddr = r_ff.ptr;
                  nxt_r.st = HD_FETCH;
               end
            end
         end
         HD_FETCH: begin
            if (!r_ff.busy) begin
               nxt_r.st = HD_ACT;
            end
         end
         HD_ACT: begin
            nxt_r.st = HD_HOLD;
            if (r_ff.rw) begin
               nxt_r.oeN = 1'b0;
               unique case (r_ff.sel)
                  SEL_CTRL: nxt_r.rdOut = r_ff.ctl;
                  SEL_PTR: nxt_r.rdOut = (r_ff.order ^ r_ff.ctl[CTL_ORDER_BIT]) ?
                     r_ff.ptr[15:0] : r_ff.ptr[31:16];
                  default: nxt_r.rdOut = (r_ff.order ^ r_ff.ctl[CTL_ORDER_BIT]) ?
                     r_ff.rbuf[15:0] : r_ff.rbuf[31:16];
               endcase
            end else begin
               unique case (r_ff.sel)
                  SEL_CTRL: begin
                     nxt_r.ctl[CTL_ORDER_BIT] = half[CTL_ORDER_BIT];
                     if (half[CTL_DEVINT_BIT]) begin
                        nxt_r.ctl[CTL_DEVINT_BIT] = 1'b1;
                        nxt_r.irq = 1'b1;
                     end
                     if (half[CTL_HOSTINT_BIT]) begin
                        nxt_r.ctl[CTL_HOSTINT_BIT] = 1'b0;
                     end
                  end
                  SEL_PTR: begin
                     if (r_ff.order ^ r_ff.ctl[CTL_ORDER_BIT]) nxt_r.ptr[15:0] = half;
                     else nxt_r.ptr[31:16] = half;
                  end
                  default: begin
                     if (r_ff.order ^ r_ff.ctl[CTL_ORDER_BIT]) begin
                        nxt_r.wbuf[15:0] = half;
                        nxt_r.wbe[1:0] = ~r_ff.b2;
                     end else begin
                        nxt_r.wbuf[31:16] = half;
                        nxt_r.wbe[3:2] = ~r_ff.b2;
                     end
                  end
               endcase
            end
            // second halfword of a data write or an incrementing data read triggers internal work
            if (r_ff.sel[1] && r_ff.order && !blocked) begin
               nxt_r.busy = 1'b1;
               nxt_r.opWrite = !r_ff.rw;
               nxt_r.opAddr = r_ff.ptr;
               if (r_ff.sel == SEL_DATA_INC) begin
                  nxt_r.ptr = r_ff.ptr + PTR_STEP;
                  if (r_ff.rw) begin
                     nxt_r.opAddr = r_ff.ptr + PTR_STEP;
                  end
               end else if (r_ff.rw) begin
                  nxt_r.busy = 1'b0;
               end
            end
         end
         HD_HOLD: begin
            if (!strobeOn) begin
               nxt_r.oeN = 1'b1;
               nxt_r.st = HD_IDLE;
            end
         end
         default: nxt_r.st = HD_IDLE;
      endcase
      if (nxt_r.busy && !r_ff.busy) begin
         nxt_r.wbe = nxt_r.opWrite ? nxt_r.wbe : 4'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r_ff <= '0;
         r_ff.st <= HD_IDLE;
         r_ff.ctl <= CTL_RESET;
         r_ff.ptr <= PTR_RESET;
         r_ff.oeN <= 1'b1;
         r_ff.s1 <= 2'h3;
         r_ff.s2 <= 2'h3;
         r_ff.wbe <= 4'hf;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign port.hostDataOut = r_ff.rdOut;
   assign port.hostDataOeN = r_ff.oeN;
   // not ready from the synced strobe on, so the host never sees a stale ready
   assign port.hostWaitOutput = !(r_ff.busy || r_ff.st == HD_ACT || r_ff.st == HD_FETCH ||
                                  (r_ff.st == HD_IDLE && strobeOn));
   assign port.hostInterruptOutputN = !r_ff.ctl[CTL_HOSTINT_BIT];
   assign auxReq = r_ff.busy;
   assign auxWrite = r_ff.opWrite;
   assign auxAddr = r_ff.opAddr;
   assign auxWData = r_ff.wbuf;
   assign auxByteEn = r_ff.wbe;
   assign cpuCtlRData = r_ff.ctl;
   assign cpuInterrupt = r_ff.irq;
endmodule

// ---- hpi_pkg.sv ----
package hpi_pkg;
   localparam logic [1:0] SEL_CTRL = 2'h0;
   localparam logic [1:0] SEL_PTR = 2'h1;
   localparam logic [1:0] SEL_DATA_INC = 2'h2;
   localparam logic [1:0] SEL_DATA_FIX = 2'h3;
   localparam logic [31:0] PTR_STEP = 32'h00000004;
   localparam int CTL_ORDER_BIT = 0;
   localparam int CTL_DEVINT_BIT = 1;
   localparam int CTL_HOSTINT_BIT = 2;
   localparam int CTL_READY_BIT = 3;
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [31:0] PTR_RESET = 32'h00000000;
   localparam logic [31:0] SKIP_BASE = 32'h01840000;
   localparam logic [31:0] SKIP_LAST = 32'h018bffff;
   localparam logic [3:0] HOST_STROBE_CYCLES = 4'h5;
endpackage

// ---- hpi_if.sv ----
`timescale 1ns/1ps
interface hpi_if;
   logic [15:0] hostDataOut;
   logic [15:0] hostDataIn;
   logic hostDataOeN;
   logic [1:0] registerSelectLines;
   logic halfwordOrderInput;
   logic [1:0] writeByteLanesN;
   logic readWriteSelect;
   logic dataStrobeOneN;
   logic dataStrobeTwoN;
   logic addrStrobeN;
   logic chipSelectN;
   logic hostWaitOutput;
   logic hostInterruptOutputN;
   modport device(output hostDataOut, hostDataOeN, hostWaitOutput, hostInterruptOutputN,
                  input hostDataIn, registerSelectLines, halfwordOrderInput, writeByteLanesN,
                  readWriteSelect, dataStrobeOneN, dataStrobeTwoN, addrStrobeN, chipSelectN);
   modport host(input hostDataOut, hostDataOeN, hostWaitOutput, hostInterruptOutputN,
                output hostDataIn, registerSelectLines, halfwordOrderInput, writeByteLanesN,
                readWriteSelect, dataStrobeOneN, dataStrobeTwoN, addrStrobeN, chipSelectN);
endinterface

// ---- hpi_host.sv ----
`timescale 1ns/1ps
module hpi_host
   import hpi_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   hpi_if.host port,
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdRead,
   input wire logic [1:0] cmdSel,
   input wire logic [31:0] cmdData,
   input wire logic [3:0] cmdByteEnN,
   output logic rspValid,
   output logic [31:0] rspData,
   output logic devInterrupt
);
   typedef enum logic [3:0] {
      HH_IDLE = 4'b0001,
      HH_SETUP = 4'b0010,
      HH_STROBE = 4'b0100,
      HH_GAP = 4'b1000
   } hh_state_t;
   typedef struct packed {
      logic [1:0] y1; // ready, interrupt sync
      logic [1:0] y2;
      logic [15:0] q1;
      logic [15:0] q2;
      hh_state_t st;
      logic second;
      logic rd;
      logic [1:0] sel;
      logic [31:0] data;
      logic [3:0] ben;
      logic [3:0] cnt;
      logic strobeN;
      logic rsp;
      logic [31:0] rdat;
   } hh_reg_t;
   hh_reg_t r_ff, nxt_r;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.y1 = {port.hostWaitOutput, !port.hostInterruptOutputN};
      nxt_r.y2 = r_ff.y1;
      nxt_r.q1 = port.hostDataOut;
      nxt_r.q2 = r_ff.q1;
      nxt_r.rsp = 1'b0;
      unique case (r_ff.st)
         HH_IDLE: begin
            if (cmdValid) begin
               nxt_r.rd = cmdRead;
               nxt_r.sel = cmdSel;
               nxt_r.data = cmdData;
               nxt_r.ben = cmdByteEnN;
               nxt_r.second = 1'b0;
               nxt_r.st = HH_SETUP;
            end
         end
         HH_SETUP: begin
            nxt_r.strobeN = 1'b0;
            nxt_r.cnt = HOST_STROBE_CYCLES;
            nxt_r.st = HH_STROBE;
         end
         HH_STROBE: begin
            if (r_ff.cnt != 4'h0) begin
               nxt_r.cnt = r_ff.cnt - 4'h1;
            end else if (r_ff.y2[1]) begin
               nxt_r.strobeN = 1'b1;
               if (r_ff.second) nxt_r.rdat[15:0] = r_ff.q2;
               else nxt_r.rdat[31:16] = r_ff.q2;
               nxt_r.st = HH_GAP;
            end
         end
         HH_GAP: begin
            if (!r_ff.second) begin
               nxt_r.second = 1'b1;
               nxt_r.st = HH_SETUP;
            end else begin
               nxt_r.rsp = 1'b1;
               nxt_r.st = HH_IDLE;
            end
         end
         default: nxt_r.st = HH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r_ff <= '0;
         r_ff.st <= HH_IDLE;
         r_ff.strobeN <= 1'b1;
         r_ff.ben <= 4'hf;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // first halfword carries the upper half of the command word
   assign port.hostDataIn = r_ff.second ? r_ff.data[15:0] : r_ff.data[31:16];
   assign port.registerSelectLines = r_ff.sel;
   assign port.halfwordOrderInput = r_ff.second;
   assign port.writeByteLanesN = r_ff.second ? r_ff.ben[1:0] : r_ff.ben[3:2];
   assign port.readWriteSelect = r_ff.rd;
   assign port.dataStrobeOneN = r_ff.strobeN;
   assign port.dataStrobeTwoN = 1'b1;
   assign port.addrStrobeN = 1'b1;
   assign port.chipSelectN = r_ff.st == HH_IDLE;
   assign cmdReady = r_ff.st == HH_IDLE;
   assign rspValid = r_ff.rsp;
   assign rspData = r_ff.rdat;
   assign devInterrupt = r_ff.y2[0];
endmodule

// ---- hpi_checker.sv ----
`timescale 1ns/1ps
module hpi_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] hostDataOut,
   input wire logic hostDataOeN,
   input wire logic [1:0] registerSelectLines,
   input wire logic halfwordOrderInput,
   input wire logic readWriteSelect,
   input wire logic dataStrobeOneN,
   input wire logic dataStrobeTwoN,
   input wire logic chipSelectN,
   input wire logic hostWaitOutput,
   input wire logic hostInterruptOutputN
);
   logic strobeOn;
   logic prevOn_ff;
   logic secondDue_ff;
   // either strobe low counts as an access
   assign strobeOn = !(dataStrobeOneN && dataStrobeTwoN);
   always_ff @(posedge clk) begin
      prevOn_ff <= strobeOn;
      if (reset)
         secondDue_ff <= 1'b0;
      else if (prevOn_ff && !strobeOn)
         secondDue_ff <= !secondDue_ff;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   reset_idle_a: assert property ($past(reset) |-> hostDataOeN && hostWaitOutput)
      else $error("port not idle after reset");
   drive_on_read_a: assert property ($fell(hostDataOeN) |-> readWriteSelect && strobeOn)
      else $error("data bus driven outside a read");
   bus_release_a: assert property ($fell(strobeOn) |-> ##[1:6] hostDataOeN)
      else $error("data bus not released after strobe");
   data_hold_a: assert property (!hostDataOeN && !$past(hostDataOeN) |-> $stable(hostDataOut))
      else $error("read halfword changed while driven");
   word_order_a: assert property (strobeOn && !prevOn_ff |-> halfwordOrderInput == secondDue_ff)
      else $error("halfword pair broken");
   ctl_stable_a: assert property (strobeOn && $past(strobeOn) |->
         $stable({registerSelectLines, halfwordOrderInput, readWriteSelect}))
      else $error("controls moved during strobe");
   wait_obeyed_a: assert property ($fell(strobeOn) |-> $past(hostWaitOutput))
      else $error("strobe ended while not ready");
   busy_shown_a: assert property ($rose(strobeOn) |-> ##[1:8] !hostWaitOutput)
      else $error("access never showed not-ready");
   strobe_width_a: assert property ($rose(strobeOn) |-> strobeOn[*4])
      else $error("strobe too short");
   select_held_a: assert property (strobeOn |-> !chipSelectN)
      else $error("strobe without chip select");
   cover property ($fell(hostDataOeN));
   cover property ($rose(strobeOn) && !readWriteSelect && registerSelectLines == 2'h2);
   cover property ($fell(hostInterruptOutputN));
endmodule

// ---- hpi_tb.sv ----
`timescale 1ns/1ps
module host_port_interface_tb;
   import hpi_pkg::*;
   logic clk = 1'b0, reset = 1'b1, cmdValid = 1'b0, cmdRead = 1'b0, auxDone = 1'b0;
   logic cpuCtlWrite = 1'b0, ord = 1'b0;
   logic cmdReady, rspValid, devInterrupt, auxReq, auxWrite, cpuInterrupt;
   logic [1:0] cmdSel = 2'h0;
   logic [3:0] cmdByteEnN = 4'h0, auxByteEn;
   logic [15:0] cpuCtlWData = 16'h0, cpuCtlRData;
   logic [31:0] cmdData = 32'h0, auxRData = 32'h0, rspData, auxAddr, auxWData, ptr, rsp;
   logic [31:0] mem [logic [31:0]];
   logic [31:0] model [logic [31:0]];
   int seed = 32'h56d8c1ad;
   int nFail = 0, checkCount = 0, cpuInts = 0;
   always #25 clk = !clk;
   hpi_if u_hpi_if();
   hpi_device u_hpi_device(.clk(clk), .reset(reset), .port(u_hpi_if), .auxReq(auxReq),
      .auxWrite(auxWrite), .auxAddr(auxAddr), .auxWData(auxWData), .auxByteEn(auxByteEn),
      .auxDone(auxDone), .auxRData(auxRData), .cpuCtlWrite(cpuCtlWrite),
      .cpuCtlWData(cpuCtlWData), .cpuCtlRData(cpuCtlRData), .cpuInterrupt(cpuInterrupt));
   hpi_host u_hpi_host(.clk(clk), .reset(reset), .port(u_hpi_if), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmdRead(cmdRead), .cmdSel(cmdSel), .cmdData(cmdData),
      .cmdByteEnN(cmdByteEnN), .rspValid(rspValid), .rspData(rspData),
      .devInterrupt(devInterrupt));
   hpi_checker u_hpi_checker(.clk(clk), .reset(reset), .hostDataOut(u_hpi_if.hostDataOut),
      .hostDataOeN(u_hpi_if.hostDataOeN), .registerSelectLines(u_hpi_if.registerSelectLines),
      .halfwordOrderInput(u_hpi_if.halfwordOrderInput),
      .readWriteSelect(u_hpi_if.readWriteSelect), .dataStrobeOneN(u_hpi_if.dataStrobeOneN),
      .dataStrobeTwoN(u_hpi_if.dataStrobeTwoN), .chipSelectN(u_hpi_if.chipSelectN),
      .hostWaitOutput(u_hpi_if.hostWaitOutput),
      .hostInterruptOutputN(u_hpi_if.hostInterruptOutputN));
   // untouched words read back as a pattern of their address
   function automatic logic [31:0] peek(ref logic [31:0] m [logic [31:0]],
         input logic [31:0] a);
      return m.exists(a) ? m[a] : a ^ 32'h3c3ca5a5;
   endfunction
   // the host sends cmdData[31:16] first, so the order bit swaps halves
   function automatic logic [31:0] swp(input logic [31:0] w);
      return ord ? {w[15:0], w[31:16]} : w;
   endfunction
   task automatic tallyAndFinish();
      if (nFail == 0 && checkCount > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checkCount++;
      if (got !== exp) begin
         nFail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic op(input logic rd, input logic [1:0] sel, input logic [31:0] d,
         input logic [3:0] benN);
      int k;
      @(posedge clk);
      #2;
      {cmdValid, cmdRead, cmdSel, cmdData, cmdByteEnN} = {1'b1, rd, sel, d, benN};
      k = 0;
      do @(posedge clk); while (cmdReady !== 1'b1 && ++k < 999);
      #2;
      cmdValid = 1'b0;
      do @(posedge clk); while (rspValid !== 1'b1 && ++k < 999);
      rsp = rspData;
      if (k >= 999) begin
         nFail++;
         tallyAndFinish();
      end
   endtask
   task automatic setPtr(input logic [31:0] a);
      ptr = a;
      op(1'b0, SEL_PTR, swp(a), 4'hf);
   endtask
   task automatic dataWr(input logic inc, input logic [31:0] d, input logic [3:0] benN);
      logic [31:0] w;
      logic [3:0] lane;
      w = peek(model, ptr);
      lane = ord ? {~benN[1:0], ~benN[3:2]} : ~benN;
      for (int b = 0; b < 4; b++)
         if (lane[b]) w[8*b +: 8] = swp(d) >> (8 * b);
      model[ptr] = w;
      op(1'b0, inc ? SEL_DATA_INC : SEL_DATA_FIX, d, benN);
      if (inc) ptr += PTR_STEP;
   endtask
   task automatic dataRd(input logic inc);
      op(1'b1, inc ? SEL_DATA_INC : SEL_DATA_FIX, 32'h0, 4'hf);
      chk("read word", swp(peek(model, ptr)), rsp);
      if (inc) ptr += PTR_STEP;
   endtask
   task automatic waitInt(input logic v);
      int k;
      for (k = 0; k < 60 && devInterrupt !== v; k++)
         @(posedge clk);
      chk("host interrupt", {31'h0, v}, {31'h0, devInterrupt});
      if (k == 60) tallyAndFinish();
   endtask
   always @(posedge clk) if (cpuInterrupt === 1'b1) cpuInts++;
   // memory behind the auxiliary channel answers after 0 to 2 idle cycles
   always begin
      @(posedge clk);
      if (auxReq === 1'b1) begin
         chk("blocked access", 32'h0, {31'h0, auxAddr >= SKIP_BASE && auxAddr <= SKIP_LAST});
         repeat ($unsigned($random(seed)) % 3) @(posedge clk);
         #2;
         auxRData = peek(mem, auxAddr);
         auxDone = 1'b1;
         if (auxWrite) begin
            for (int b = 0; b < 4; b++)
               if (auxByteEn[b]) auxRData[8*b +: 8] = auxWData[8*b +: 8];
            mem[auxAddr] = auxRData;
         end
         @(posedge clk);
         #2;
         auxDone = 1'b0;
         auxRData = ~auxRData;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      #2;
      reset = 1'b0;
      for (int o = 0; o < 2; o++) begin
         ord = o[0];
         op(1'b0, SEL_CTRL, {2{15'h0, ord}}, 4'hf);
         repeat (4) @(posedge clk);
         chk("cpu control", {30'h0, 1'b1, ord}, {30'h0, cpuCtlRData[3], cpuCtlRData[0]});
         setPtr({16'h0, 12'($random(seed)), 4'h0});
         for (int i = 0; i < 3; i++)
            dataWr(1'b1, $random(seed), 4'h0);
         dataWr(1'b0, $random(seed), 4'($random(seed)));
         setPtr(ptr - 32'h0000000c);
         dataRd(1'b0);
         for (int i = 0; i < 4; i++)
            dataRd(1'b1);
         op(1'b1, SEL_PTR, 32'h0, 4'hf);
         chk("pointer", swp(ptr), rsp);
      end
      op(1'b0, SEL_CTRL, {16'h0003, 16'h0001}, 4'hf);
      repeat (4) @(posedge clk);
      chk("cpu interrupts", 32'h1, cpuInts);
      cpuCtlWData = 16'h0005;
      @(posedge clk);
      #2;
      cpuCtlWrite = 1'b1;
      @(posedge clk);
      #2;
      cpuCtlWrite = 1'b0;
      waitInt(1'b1);
      op(1'b0, SEL_CTRL, {2{16'h0005}}, 4'hf);
      waitInt(1'b0);
      op(1'b1, SEL_CTRL, 32'h0, 4'hf);
      chk("host control", 32'h3, {29'h0, rsp[2:0]});
      setPtr(SKIP_BASE);
      op(1'b0, SEL_DATA_FIX, 32'h0, 4'h0);
      tallyAndFinish();
   end
endmodule
